// [inc/kss_regs.vh]
// Constants for the key sensing setup command block.
// Assumes a 125 MHz clock and an APB register bus with 32-bit data.
`ifndef KSS_REGS_VH
`define KSS_REGS_VH

// APB byte offsets
`define KSS_OFF_CMD 8'h00
`define KSS_OFF_RESP 8'h04
`define KSS_OFF_KSEL 8'h08
`define KSS_OFF_KSTAT 8'h0c
`define KSS_OFF_THR 8'h10
`define KSS_OFF_GLOB 8'h14

// Command register fields
`define KSS_CMD_CODE 7:0
`define KSS_CMD_VAL 15:8
`define KSS_CMD_PUT 16
`define KSS_CMD_SCOPE 18:17
`define KSS_CMD_KEY 24:19

// Scope encodings
`define KSS_SC_KEY 2'h0
`define KSS_SC_ROW 2'h1
`define KSS_SC_COL 2'h2
`define KSS_SC_ALL 2'h3

// Command codes
`define KSS_C_NDRIFT 8'h08
`define KSS_C_PDRIFT 8'h09
`define KSS_C_INTEG 8'h0a
`define KSS_C_PRECAL 8'h0b
`define KSS_C_NRECAL 8'h0c
`define KSS_C_PSPACE 8'h0d
`define KSS_C_PBAND 8'h0e
`define KSS_C_NBAND 8'h0f
`define KSS_C_LOCK 8'h4c
`define KSS_C_RECAL 8'h62

// Value limits
`define KSS_PSPACE_MIN 8'h02
`define KSS_PSPACE_MAX 8'h0a
`define KSS_PBAND_MAX 8'h64
`define KSS_NBAND_MAX 8'h63
`define KSS_PBAND_DIV 16'h000a
`define KSS_NBAND_DIV 16'h0064

// Default settings loaded by nv_init, except dwell, which reset loads
`define KSS_DEF_NDRIFT 8'h14
`define KSS_DEF_PDRIFT 8'h05
`define KSS_DEF_INTEG 8'h02
`define KSS_DEF_PRECAL 8'h0a
`define KSS_DEF_NRECAL 8'h0a
`define KSS_DEF_PSPACE 8'h05
`define KSS_DEF_DWELL 8'h01

// Timing
`define KSS_CLK_NS 8
`define KSS_UNIT_MS 100
`define KSS_NRECAL_UNIT 16'h000a
`define KSS_US_NS 1000
`define KSS_US_CYC 12'h07d

`endif

// [rtl/kss_setup.v]
// Sensing setup commands, their per-key store and the sensing logic they steer.
// Assumes one burst result per burst request and an APB master on mclk.
//
// Contract
// R1 - Negative drift rate only from sixteen values
// R2 - Drift step every rate times 100 ms
// R3 - No negative drift while below threshold
// R4 - Group get returns lowest ranked key
// R5 - Put updates every key in scope
// R6 - Positive drift same values, above reference
// R7 - No positive drift while above threshold
// R8 - Detect after limit consecutive detect bursts
// R9 - One burst per key per scan
// R10 - Limit zero never detects, burst kept
// R11 - Positive recal delay in 100 ms
// R12 - Zero positive delay disables positive recal
// R13 - Negative recal delay in one second
// R14 - Zero negative delay disables negative recal
// R15 - Global pulse spacing 2 to 10 us
// R16 - Dwell above one lengthens pulse spacing
// R17 - Positive band 0..100, tenfold percent
// R18 - Flag key whose reference exceeds band
// R19 - Band flag only after recalibrate command
// R20 - Host recalibrates keys with extreme references
// R21 - Positive band zero disables check
// R22 - Negative band under own code
// R23 - Negative drift rate own code, echoed
// R24 - Negative band 0..99 percent, zero disables
// R25 - Valid put stored for all scoped keys
// R26 - Discarded put keeps old settings
`timescale 1ns/1ns
`include "kss_regs.vh"

module kss_setup #(
   parameter [31:0] TICK_CYC = (`KSS_UNIT_MS * 1000000) / `KSS_CLK_NS
) (
   // Clock and reset
   input wire mclk,
   input wire rstn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Settings store load with defaults
   input wire nv_init,
   // Burst sequencer
   output reg burst_go,
   output reg [5:0] burst_key,
   input wire burst_done,
   input wire [7:0] burst_signal,
   // Per-key results
   output reg [63:0] key_detect,
   output reg [63:0] key_error,
   // Effective pulse spacing in clock cycles
   output reg [11:0] pulse_gap_cyc
);

   // Retained setup store
   reg [7:0] ndrift_m [0:63];
   reg [7:0] pdrift_m [0:63];
   reg [7:0] integ_m [0:63];
   reg [7:0] precal_m [0:63];
   reg [7:0] nrecal_m [0:63];
   reg [7:0] pspace_r;
   reg [7:0] pband_r;
   reg [7:0] nband_r;
   reg [7:0] dwell_r;
   // Per-key sensing state
   reg [7:0] ref_m [0:63];
   reg [7:0] lock_m [0:63];
   reg [7:0] icnt_m [0:63];
   reg [15:0] dstamp_m [0:63];
   reg [15:0] nstamp_m [0:63];
   reg [15:0] pstamp_m [0:63];
   reg [63:0] nsusp_r;
   reg [63:0] psusp_r;
   reg [63:0] cal_r;
   reg [63:0] pend_r;
   // Command side
   reg [7:0] resp_r;
   reg resp_ok_r;
   reg resp_drop_r;
   reg [5:0] ksel_r;
   reg [31:0] thr_r;
   reg recal_req_r;
   reg lock_req_r;
   reg [1:0] req_scope_r;
   reg [5:0] req_key_r;
   // Time base
   reg [31:0] tick_cnt_r;
   reg [15:0] now_r;
   reg busy_r;
   integer k;

   // Membership of key k in a scope
   function in_scope;
      input [5:0] kk;
      input [1:0] sc;
      input [5:0] key;
      begin
         case (sc)
            `KSS_SC_KEY: in_scope = (kk == key);
            `KSS_SC_ROW: in_scope = (kk[5:3] == key[5:3]);
            `KSS_SC_COL: in_scope = (kk[2:0] == key[2:0]);
            default: in_scope = 1'b1;
         endcase
      end
   endfunction

   // Lowest ranked key of a scope
   function [5:0] low_key;
      input [1:0] sc;
      input [5:0] key;
      begin
         case (sc)
            `KSS_SC_KEY: low_key = key;
            `KSS_SC_ROW: low_key = {key[5:3], 3'h0};
            `KSS_SC_COL: low_key = {3'h0, key[2:0]};
            default: low_key = 6'h00;
         endcase
      end
   endfunction

   // Drift rate value set
   function ok_rate;
      input [7:0] v;
      begin
         case (v)
            8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c,
            8'h0f, 8'h14, 8'h19, 8'h21, 8'h2d, 8'h3c, 8'h4b, 8'h64: ok_rate = 1'b1;
            default: ok_rate = 1'b0;
         endcase
      end
   endfunction

   // Integrator and recal delay value set
   function ok_lim;
      input [7:0] v;
      begin
         case (v)
            8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0a, 8'h0f,
            8'h14, 8'h20, 8'h2d, 8'h3c, 8'h5a, 8'h7b, 8'haf, 8'hff: ok_lim = 1'b1;
            default: ok_lim = 1'b0;
         endcase
      end
   endfunction

   // APB decode
   wire [7:0] cw_code = pwdata[`KSS_CMD_CODE];
   wire [7:0] cw_val = pwdata[`KSS_CMD_VAL];
   wire cw_put = pwdata[`KSS_CMD_PUT];
   wire [1:0] cw_sc = pwdata[`KSS_CMD_SCOPE];
   wire [5:0] cw_key = pwdata[`KSS_CMD_KEY];
   wire [5:0] cw_low = low_key(cw_sc, cw_key);
   wire acc = psel & penable;
   wire wr_cmd = acc & pwrite & (paddr == `KSS_OFF_CMD);
   wire mapped = (paddr == `KSS_OFF_CMD) | (paddr == `KSS_OFF_RESP) |
      (paddr == `KSS_OFF_KSEL) | (paddr == `KSS_OFF_KSTAT) |
      (paddr == `KSS_OFF_THR) | (paddr == `KSS_OFF_GLOB);
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   // Validity of a put by command
   reg put_ok;
   reg known;
   always @* begin
      put_ok = 1'b0;
      known = 1'b1;
      case (cw_code)
         `KSS_C_NDRIFT, `KSS_C_PDRIFT: put_ok = ok_rate(cw_val); // R1 R6
         `KSS_C_INTEG, `KSS_C_PRECAL, `KSS_C_NRECAL: put_ok = ok_lim(cw_val); // R8 R11 R13
         `KSS_C_PSPACE: put_ok = (cw_val >= `KSS_PSPACE_MIN) &&
            (cw_val <= `KSS_PSPACE_MAX); // R15
         `KSS_C_PBAND: put_ok = (cw_val <= `KSS_PBAND_MAX); // R17
         `KSS_C_NBAND: put_ok = (cw_val <= `KSS_NBAND_MAX); // R22 R24
         `KSS_C_LOCK, `KSS_C_RECAL: put_ok = 1'b1;
         default: known = 1'b0;
      endcase
   end

   // Get value by command
   reg [7:0] get_val;
   always @* begin
      case (cw_code)
         `KSS_C_NDRIFT: get_val = ndrift_m[cw_low]; // R4
         `KSS_C_PDRIFT: get_val = pdrift_m[cw_low];
         `KSS_C_INTEG: get_val = integ_m[cw_low];
         `KSS_C_PRECAL: get_val = precal_m[cw_low];
         `KSS_C_NRECAL: get_val = nrecal_m[cw_low];
         `KSS_C_PSPACE: get_val = pspace_r; // R15
         `KSS_C_PBAND: get_val = pband_r;
         `KSS_C_NBAND: get_val = nband_r;
         default: get_val = 8'h00;
      endcase
   end

   // Setup store, loaded by nv_init, otherwise written only by a valid put
   always @(posedge mclk) begin
      if (nv_init) begin
         for (k = 0; k < 64; k = k + 1) begin
            ndrift_m[k] <= `KSS_DEF_NDRIFT;
            pdrift_m[k] <= `KSS_DEF_PDRIFT;
            integ_m[k] <= `KSS_DEF_INTEG;
            precal_m[k] <= `KSS_DEF_PRECAL;
            nrecal_m[k] <= `KSS_DEF_NRECAL;
         end
         pspace_r <= `KSS_DEF_PSPACE;
         pband_r <= 8'h00;
         nband_r <= 8'h00;
      end else if (wr_cmd && cw_put && put_ok) begin
         for (k = 0; k < 64; k = k + 1) begin
            if (in_scope(k[5:0], cw_sc, cw_key)) begin // R5 R25
               if (cw_code == `KSS_C_NDRIFT) ndrift_m[k] <= cw_val; // R23
               if (cw_code == `KSS_C_PDRIFT) pdrift_m[k] <= cw_val;
               if (cw_code == `KSS_C_INTEG) integ_m[k] <= cw_val;
               if (cw_code == `KSS_C_PRECAL) precal_m[k] <= cw_val;
               if (cw_code == `KSS_C_NRECAL) nrecal_m[k] <= cw_val;
            end
         end
         if (cw_code == `KSS_C_PSPACE) pspace_r <= cw_val;
         if (cw_code == `KSS_C_PBAND) pband_r <= cw_val;
         if (cw_code == `KSS_C_NBAND) nband_r <= cw_val;
      end
   end

   // Command answer and control registers
   always @(posedge mclk) begin
      if (!rstn) begin
         resp_r <= 8'h00;
         resp_ok_r <= 1'b0;
         resp_drop_r <= 1'b0;
         ksel_r <= 6'h00;
         thr_r <= 32'h00000000;
         dwell_r <= `KSS_DEF_DWELL;
         recal_req_r <= 1'b0;
         lock_req_r <= 1'b0;
         req_scope_r <= `KSS_SC_KEY;
         req_key_r <= 6'h00;
      end else begin
         recal_req_r <= wr_cmd & cw_put & (cw_code == `KSS_C_RECAL);
         lock_req_r <= wr_cmd & cw_put & (cw_code == `KSS_C_LOCK);
         if (wr_cmd) begin
            req_scope_r <= cw_sc;
            req_key_r <= cw_key;
            resp_ok_r <= known & (~cw_put | put_ok);
            resp_drop_r <= ~known | (cw_put & ~put_ok); // R26
            resp_r <= cw_put ? (put_ok ? cw_code : 8'h00) : get_val; // R23
         end
         if (acc && pwrite && paddr == `KSS_OFF_KSEL) ksel_r <= pwdata[5:0];
         if (acc && pwrite && paddr == `KSS_OFF_THR) thr_r <= pwdata;
         if (acc && pwrite && paddr == `KSS_OFF_GLOB) dwell_r <= pwdata[7:0];
      end
   end

   // Read data captured in the setup phase
   always @(posedge mclk) begin
      if (!rstn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `KSS_OFF_RESP: prdata <= {22'h000000, resp_drop_r, resp_ok_r, resp_r};
            `KSS_OFF_KSEL: prdata <= {26'h0000000, ksel_r};
            `KSS_OFF_KSTAT: prdata <= {12'h000, cal_r[ksel_r], key_error[ksel_r],
               key_detect[ksel_r], nsusp_r[ksel_r], lock_m[ksel_r], ref_m[ksel_r]};
            `KSS_OFF_THR: prdata <= thr_r;
            `KSS_OFF_GLOB: prdata <= {nband_r, pband_r, pspace_r, dwell_r};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // Effective pulse spacing grows with dwell
   always @(posedge mclk) begin
      if (!rstn) begin
         pulse_gap_cyc <= 12'h000;
      end else begin
         pulse_gap_cyc <= pspace_r[3:0] * `KSS_US_CYC + {4'h0, dwell_r} - 12'h001; // R16
      end
   end

   // 100 ms time base
   always @(posedge mclk) begin
      if (!rstn) begin
         tick_cnt_r <= 32'h00000000;
         now_r <= 16'h0000;
      end else if (tick_cnt_r >= TICK_CYC - 32'h00000001) begin
         tick_cnt_r <= 32'h00000000;
         now_r <= now_r + 16'h0001; // R2
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h00000001;
      end
   end

   // Scan sequencer: every slot in turn, disabled keys too
   always @(posedge mclk) begin
      if (!rstn) begin
         burst_go <= 1'b0;
         burst_key <= 6'h00;
         busy_r <= 1'b0;
      end else begin
         burst_go <= ~busy_r;
         if (!busy_r) begin
            busy_r <= 1'b1; // R9 R10
         end else if (burst_done) begin
            busy_r <= 1'b0;
            burst_key <= burst_key + 6'h01; // R9
         end
      end
   end

   // Per-burst evaluation of the current key
   wire [5:0] bk = burst_key;
   wire [7:0] rf = ref_m[bk];
   wire [7:0] lk = lock_m[bk];
   wire [9:0] s10 = {2'h0, burst_signal};
   wire [9:0] r10 = {2'h0, rf};
   wire below = (s10 + {2'h0, thr_r[7:0]}) < r10;
   wire above_nhys = (s10 + {2'h0, thr_r[15:8]}) >= r10;
   wire over = s10 > (r10 + {2'h0, thr_r[23:16]});
   wire under_phys = s10 <= (r10 + {2'h0, thr_r[31:24]});
   wire nsus = below | (nsusp_r[bk] & ~above_nhys);
   wire psus = over | (psusp_r[bk] & ~under_phys);
   wire [15:0] d_el = now_r - dstamp_m[bk];
   wire [15:0] n_el = now_r - nstamp_m[bk];
   wire [15:0] p_el = now_r - pstamp_m[bk];
   wire [7:0] rate = (burst_signal < rf) ? ndrift_m[bk] : pdrift_m[bk];
   wire drift_dn = (burst_signal < rf) & ~nsus & (d_el >= {8'h00, rate}); // R2 R3
   wire drift_up = (burst_signal > rf) & ~psus & (d_el >= {8'h00, rate}); // R6 R7
   wire [15:0] nlim = {8'h00, nrecal_m[bk]} * `KSS_NRECAL_UNIT;
   wire nrec = nsusp_r[bk] & nsus & (nrecal_m[bk] != 8'h00) & (n_el >= nlim); // R13 R14
   wire prec = psusp_r[bk] & psus & (precal_m[bk] != 8'h00) &
      (p_el >= {8'h00, precal_m[bk]}); // R11 R12
   wire recal = nrec | prec | pend_r[bk];
   wire [7:0] icnt_nx = (icnt_m[bk] == 8'hff) ? icnt_m[bk] : icnt_m[bk] + 8'h01;
   wire [15:0] l16 = {8'h00, lk};
   wire [15:0] plim = l16 + (l16 * {8'h00, pband_r}) / `KSS_PBAND_DIV; // R17
   wire [15:0] nlo = l16 - (l16 * {8'h00, nband_r}) / `KSS_NBAND_DIV; // R24
   wire perr = (pband_r != 8'h00) & ({8'h00, rf} > plim); // R18 R21
   wire nerr = (nband_r != 8'h00) & ({8'h00, rf} < nlo); // R24

   // Sensing state update
   always @(posedge mclk) begin
      if (!rstn) begin
         for (k = 0; k < 64; k = k + 1) begin
            ref_m[k] <= 8'h00;
            lock_m[k] <= 8'h00;
            icnt_m[k] <= 8'h00;
            dstamp_m[k] <= 16'h0000;
            nstamp_m[k] <= 16'h0000;
            pstamp_m[k] <= 16'h0000;
         end
         nsusp_r <= 64'h0;
         psusp_r <= 64'h0;
         cal_r <= 64'h0;
         pend_r <= 64'h0;
         key_detect <= 64'h0;
         key_error <= 64'h0;
      end else begin
         if (busy_r && burst_done) begin
            if (recal) begin
               ref_m[bk] <= burst_signal;
               nsusp_r[bk] <= 1'b0;
               psusp_r[bk] <= 1'b0;
               icnt_m[bk] <= 8'h00;
               key_detect[bk] <= 1'b0;
               dstamp_m[bk] <= now_r;
               if (pend_r[bk]) cal_r[bk] <= 1'b1; // R19
               pend_r[bk] <= 1'b0;
            end else begin
               nsusp_r[bk] <= nsus;
               psusp_r[bk] <= psus;
               if (below && !nsusp_r[bk]) nstamp_m[bk] <= now_r; // R13
               if (over && !psusp_r[bk]) pstamp_m[bk] <= now_r; // R11
               if (drift_dn) ref_m[bk] <= rf - 8'h01;
               else if (drift_up) ref_m[bk] <= rf + 8'h01;
               if (drift_dn || drift_up || burst_signal == rf) dstamp_m[bk] <= now_r;
               if (below) begin
                  icnt_m[bk] <= icnt_nx;
                  key_detect[bk] <= (integ_m[bk] != 8'h00) &&
                     (icnt_nx >= integ_m[bk]); // R8 R10
               end else begin
                  icnt_m[bk] <= 8'h00; // R8
                  key_detect[bk] <= 1'b0;
               end
            end
            key_error[bk] <= cal_r[bk] & (perr | nerr); // R18 R19
         end
         // Recalibrate and lock requests from commands
         for (k = 0; k < 64; k = k + 1) begin
            if (recal_req_r && in_scope(k[5:0], req_scope_r, req_key_r)) pend_r[k] <= 1'b1;
            if (lock_req_r) lock_m[k] <= ref_m[k];
         end
      end
   end

endmodule

// [tb/kss_setup_props.sv]
// Port checks for the sensing setup block: bus answers and burst sequencing.
// Assumes it is bound to kss_setup, one clock, synchronous active-low reset.
`timescale 1ns/1ns
module kss_setup_props #(
   parameter [31:0] TICK_CYC = 32'h14
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Store load and burst link
   input wire logic nv_init,
   input wire logic burst_go,
   input wire logic [5:0] burst_key,
   input wire logic burst_done,
   input wire logic [7:0] burst_signal,
   // Results
   input wire logic [63:0] key_detect,
   input wire logic [63:0] key_error,
   input wire logic [11:0] pulse_gap_cyc
);
   reg busy_r;
   wire map_w;
   // Mapped words run from the command word to the global word
   assign map_w = paddr[1:0] == 2'h0 && paddr <= 8'h14;
   // Burst in flight from request to result
   always @(posedge mclk) begin
      if (!rstn)
         busy_r <= 1'b0;
      else if (burst_go)
         busy_r <= 1'b1;
      else if (burst_done)
         busy_r <= 1'b0;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_accept;
      busy_r && burst_done;
   endsequence
   AST_PREADY: assert property (s_access |-> pready)
      else $error("access phase without ready");
   AST_SLVERR_BAD: assert property (s_access and !map_w |-> pslverr)
      else $error("unmapped access not refused");
   AST_SLVERR_OK: assert property (s_access and map_w |-> !pslverr)
      else $error("mapped access refused");
   AST_BAD_READ_ZERO: assert property (s_access and !pwrite && !map_w |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   AST_KEY_ADV: assert property (s_accept |=> !burst_go &&
      burst_key == $past(burst_key) + 6'h1 ##1 burst_go)
      else $error("scan slot did not advance by one");
   AST_KEY_HOLD: assert property (busy_r && !burst_done |=> $stable(burst_key))
      else $error("burst key moved during burst");
   AST_GO_PULSE: assert property (burst_go |=> !burst_go ##1 !burst_go)
      else $error("burst request longer than one cycle");
   AST_DETECT_LOCAL: assert property (key_detect != $past(key_detect) |->
      $past(busy_r && burst_done) &&
      ((key_detect ^ $past(key_detect)) & ~(64'h1 << $past(burst_key))) == 64'h0)
      else $error("detect changed outside its key burst");
   AST_ERROR_LOCAL: assert property (key_error != $past(key_error) |->
      $past(busy_r && burst_done) &&
      ((key_error ^ $past(key_error)) & ~(64'h1 << $past(burst_key))) == 64'h0)
      else $error("error flag changed outside its key burst");
endmodule
bind kss_setup kss_setup_props #(.TICK_CYC(TICK_CYC)) u_props (.mclk(mclk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .nv_init(nv_init),
   .burst_go(burst_go), .burst_key(burst_key), .burst_done(burst_done),
   .burst_signal(burst_signal), .key_detect(key_detect), .key_error(key_error),
   .pulse_gap_cyc(pulse_gap_cyc));

// [tb/kss_sensor_model.sv]
// Burst sensor model: one result for each burst request.
// Assumes the bench sets the reported level; odd keys answer slowly.
`timescale 1ns/1ns
module kss_sensor_model (
   // Clock and reset
   input wire mclk,
   input wire rstn,
   // Burst request and level to report
   input wire burst_go,
   input wire [5:0] burst_key,
   input wire [7:0] level,
   // Burst result
   output reg burst_done,
   output reg [7:0] burst_signal
);
   reg [2:0] wait_r;
   reg run_r;
   // Result invalid outside its pulse, so the data line keeps toggling
   always @(posedge mclk) begin
      burst_done <= 1'b0;
      burst_signal <= ~burst_signal;
      if (!rstn) begin
         run_r <= 1'b0;
         wait_r <= 3'h0;
         burst_signal <= 8'h5a;
      end else if (burst_go) begin
         run_r <= 1'b1;
         wait_r <= burst_key[0] ? 3'h4 : 3'h0;
      end else if (run_r && wait_r != 3'h0) begin
         wait_r <= wait_r - 3'h1;
      end else if (run_r) begin
         run_r <= 1'b0;
         burst_done <= 1'b1;
         burst_signal <= level;
      end
   end
endmodule

// [tb/kss_setup_test.sv]
// Bench for the sensing setup block: commands over APB, sensing with a burst model.
// Assumes the store is loaded by one nv_init pulse and ticks are 20 cycles.
`timescale 1ns/1ns
`include "kss_regs.vh"
module kss_setup_test;
   reg mclk, rstn, psel, penable, pwrite, nv_init, err;
   reg [7:0] paddr, level;
   reg [31:0] pwdata, rd;
   wire [31:0] prdata;
   wire pready, pslverr, burst_go, burst_done;
   wire [5:0] burst_key;
   wire [7:0] burst_signal;
   wire [63:0] key_detect, key_error;
   wire [11:0] pulse_gap_cyc;
   integer fail_count, checks;
   kss_setup #(.TICK_CYC(32'h14)) dut (.mclk(mclk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nv_init(nv_init), .burst_go(burst_go),
      .burst_key(burst_key), .burst_done(burst_done), .burst_signal(burst_signal),
      .key_detect(key_detect), .key_error(key_error), .pulse_gap_cyc(pulse_gap_cyc));
   kss_sensor_model u_sensor (.mclk(mclk), .rstn(rstn), .burst_go(burst_go),
      .burst_key(burst_key), .level(level), .burst_done(burst_done),
      .burst_signal(burst_signal));
   // Clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task check(input [8*8:1] name, input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // One APB transfer, then one idle edge
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge mclk);
         penable <= 1'b1;
         @(posedge mclk);
         while (pready !== 1'b1)
            @(posedge mclk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge mclk);
      end
   endtask
   task cmd(input [7:0] code, input [7:0] v, input put, input [1:0] sc, input [5:0] key);
      begin
         apb(1'b1, `KSS_OFF_CMD, {7'h0, key, sc, put, v, code});
         apb(1'b0, `KSS_OFF_RESP, 32'h0);
      end
   endtask
   task put_chk(input [7:0] code, input [7:0] v, input [1:0] sc, input [5:0] key);
      begin
         cmd(code, v, 1'b1, sc, key);
         check("echo", rd, {22'h0, 2'h1, code});
      end
   endtask
   task get_chk(input [7:0] code, input [1:0] sc, input [5:0] key, input [7:0] v);
      begin
         cmd(code, 8'h00, 1'b0, sc, key);
         check("get", rd, {22'h0, 2'h1, v});
      end
   endtask
   task drop_chk(input [7:0] code, input [7:0] v);
      begin
         cmd(code, v, 1'b1, 2'h3, 6'h07);
         check("drop", rd, 32'h200);
      end
   endtask
   // Every listed value is kept, two unlisted ones leave it alone
   task t_list(input [7:0] code, input [127:0] tab, input [7:0] bad0, input [7:0] bad1);
      integer j;
      begin
         for (j = 0; j < 16; j = j + 1) begin
            put_chk(code, tab[127 - 8 * j -: 8], 2'h0, 6'h07);
            get_chk(code, 2'h0, 6'h07, tab[127 - 8 * j -: 8]);
         end
         drop_chk(code, bad0);
         drop_chk(code, bad1);
         get_chk(code, 2'h0, 6'h07, tab[7:0]);
         $display("list %h done", code);
      end
   endtask
   // Row and column puts reach only their keys
   task t_scope;
      begin
         put_chk(`KSS_C_INTEG, 8'h05, 2'h1, 6'h0d);
         get_chk(`KSS_C_INTEG, 2'h0, 6'h0f, 8'h05);
         get_chk(`KSS_C_INTEG, 2'h0, 6'h10, `KSS_DEF_INTEG);
         get_chk(`KSS_C_INTEG, 2'h1, 6'h0d, 8'h05);
         put_chk(`KSS_C_PDRIFT, 8'h3c, 2'h2, 6'h03);
         get_chk(`KSS_C_PDRIFT, 2'h0, 6'h3b, 8'h3c);
         get_chk(`KSS_C_PDRIFT, 2'h0, 6'h3a, `KSS_DEF_PDRIFT);
         get_chk(`KSS_C_PDRIFT, 2'h2, 6'h3b, 8'h3c);
         get_chk(`KSS_C_PDRIFT, 2'h3, 6'h28, `KSS_DEF_PDRIFT);
         $display("scope done");
      end
   endtask
   // Global settings, their limits and the pulse gap
   task t_global;
      begin
         check("gap", pulse_gap_cyc, 32'h271);
         put_chk(`KSS_C_PSPACE, 8'h0a, 2'h3, 6'h00);
         check("gap", pulse_gap_cyc, 32'h4e2);
         drop_chk(`KSS_C_PSPACE, 8'h0b);
         drop_chk(`KSS_C_PSPACE, 8'h01);
         put_chk(`KSS_C_PSPACE, 8'h02, 2'h3, 6'h00);
         get_chk(`KSS_C_PSPACE, 2'h3, 6'h00, 8'h02);
         apb(1'b1, `KSS_OFF_GLOB, 32'h3);
         apb(1'b0, `KSS_OFF_GLOB, 32'h0);
         check("glob", rd[15:0], 32'h203);
         check("gap", pulse_gap_cyc, 32'hfc);
         apb(1'b1, `KSS_OFF_GLOB, 32'h1);
         put_chk(`KSS_C_PBAND, 8'h64, 2'h3, 6'h00);
         drop_chk(`KSS_C_PBAND, 8'h65);
         get_chk(`KSS_C_PBAND, 2'h3, 6'h00, 8'h64);
         put_chk(`KSS_C_NBAND, 8'h63, 2'h3, 6'h00);
         drop_chk(`KSS_C_NBAND, 8'h64);
         get_chk(`KSS_C_NBAND, 2'h3, 6'h00, 8'h63);
         put_chk(`KSS_C_PBAND, 8'h00, 2'h3, 6'h00);
         put_chk(`KSS_C_NBAND, 8'h00, 2'h3, 6'h00);
         apb(1'b0, 8'h18, 32'h0);
         check("bad_rd", rd, 32'h0);
         check("bad_err", err, 32'h1);
         apb(1'b1, 8'h40, 32'h1);
         check("bad_wr", err, 32'h1);
         $display("global done");
      end
   endtask
   task scans(input integer n);
      integer k;
      begin
         repeat (n * 64) begin
            k = 0;
            @(posedge mclk);
            while (burst_done !== 1'b1 && k < 20) begin
               @(posedge mclk);
               k = k + 1;
            end
            check("burst", burst_done, 32'h1);
         end
         @(posedge mclk);
      end
   endtask
   // Recalibrate, then hold a touch on every key
   task t_sense;
      begin
         apb(1'b1, `KSS_OFF_THR, 32'h00ff000a);
         put_chk(`KSS_C_NRECAL, 8'h00, 2'h3, 6'h00);
         put_chk(`KSS_C_PRECAL, 8'h00, 2'h3, 6'h00);
         put_chk(`KSS_C_INTEG, 8'h01, 2'h3, 6'h00);
         put_chk(`KSS_C_INTEG, 8'h00, 2'h0, 6'h00);
         put_chk(`KSS_C_INTEG, 8'hff, 2'h0, 6'h02);
         level <= 8'h64;
         put_chk(`KSS_C_RECAL, 8'h00, 2'h3, 6'h00);
         scans(2);
         apb(1'b1, `KSS_OFF_KSEL, 32'h5);
         apb(1'b0, `KSS_OFF_KSTAT, 32'h0);
         check("stat", {rd[19], rd[17], rd[7:0]}, 32'h264);
         level <= 8'h50;
         scans(4);
         check("det1", key_detect[1], 32'h1);
         check("det0", key_detect[0], 32'h0);
         check("det2", key_detect[2], 32'h0);
         apb(1'b0, `KSS_OFF_KSTAT, 32'h0);
         check("stat", {rd[18:16], rd[7:0]}, 32'h364);
         put_chk(`KSS_C_PBAND, 8'h01, 2'h3, 6'h00);
         scans(1);
         check("err5", key_error[5], 32'h1);
         $display("sense done");
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", checks, fail_count);
         if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // Watchdog
   initial begin
      repeat (60000) @(posedge mclk);
      fail_count = fail_count + 1;
      complete_run;
   end
   // Main sequence
   initial begin
      fail_count = 0;
      checks = 0;
      {rstn, psel, penable, pwrite, nv_init, err} = 6'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      level = 8'h64;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      nv_init <= 1'b1;
      @(posedge mclk);
      nv_init <= 1'b0;
      @(posedge mclk);
      t_list(`KSS_C_NDRIFT, 128'h01020304_06080a0c_0f141921_2d3c4b64, 8'h00, 8'h05);
      t_list(`KSS_C_PDRIFT, 128'h01020304_06080a0c_0f141921_2d3c4b64, 8'h00, 8'h65);
      t_list(`KSS_C_INTEG, 128'h00010203_05070a0f_14202d3c_5a7bafff, 8'h04, 8'hfe);
      t_list(`KSS_C_PRECAL, 128'h00010203_05070a0f_14202d3c_5a7bafff, 8'h04, 8'hfe);
      t_list(`KSS_C_NRECAL, 128'h00010203_05070a0f_14202d3c_5a7bafff, 8'h04, 8'hfe);
      t_scope;
      t_global;
      t_sense;
      complete_run;
   end
endmodule
